// ---- hw/cpi_cfg.svh ----
// constants for the coprocessor interface port: offsets, fields, codes
`ifndef CPI_CFG_SVH
`define CPI_CFG_SVH
// coprocessor-side register offsets
`define CPI_CIR_RESPONSE 5'h00
`define CPI_CIR_OPWORD 5'h08
`define CPI_CIR_COMMAND 5'h0A
`define CPI_CIR_CONDITION 5'h0E
`define CPI_CIR_OPERAND 5'h10
`define CPI_CIR_REGSEL 5'h14
`define CPI_CIR_IADDR 5'h18
`define CPI_CIR_OPADDR 5'h1C
// primitive function codes in bits 12..8
`define CPI_FN_NULL 5'h02
`define CPI_FN_OPWORD 5'h03
`define CPI_FN_OPERAND 5'h04
`define CPI_FN_REGSEL 5'h05
`define CPI_FN_IADDR 5'h06
`define CPI_FN_OPADDR 5'h07
`define CPI_FN_EXTSKIP 5'h08
// software-side AHB byte offsets
`define CPI_AHB_CTRL 8'h00
`define CPI_AHB_OPWORD 8'h04
`define CPI_AHB_CMD 8'h08
`define CPI_AHB_COND 8'h0C
`define CPI_AHB_PCADDR 8'h10
`define CPI_AHB_OPDATA 8'h14
`define CPI_AHB_OPADDR 8'h18
`define CPI_AHB_STATUS 8'h1C
`define CPI_AHB_SCAN 8'h20
`define CPI_AHB_REGSEL 8'h24
`define CPI_AHB_RESP 8'h28
// control and status bit positions
`define CPI_CTRL_START 0
`define CPI_ST_DONE 1
`define CPI_ST_PROTO 2
// instruction stream steps, in bytes
`define CPI_WORD_STEP 32'h0000_0002
`define CPI_LONG_BYTES 4'h4
`endif

// ---- hw/cpi_pkg.sv ----
// types shared by the coprocessor interface port
package cpi_pkg;
    // dialogue sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000, ST_INIT = 4'b0001, ST_READ_RESP = 4'b0010,
        ST_LATCH = 4'b0011, ST_DECODE = 4'b0100, ST_CAPTURE = 4'b0101,
        ST_OPERAND = 4'b0110, ST_OPW_WAIT = 4'b0111, ST_OPR_WAIT = 4'b1000,
        ST_FINISH = 4'b1001, ST_BUS = 4'b1010
    } cpi_state_type;
    // instruction categories set by software
    typedef enum logic [2:0] {
        CAT_GENERAL = 3'b000, CAT_BRANCH = 3'b001, CAT_SET = 3'b010,
        CAT_TRAP = 3'b011, CAT_DBRANCH = 3'b100
    } cpi_cat_type;
    // one access toward the coprocessor register set
    typedef struct packed {
        logic [4:0] addr;
        logic wide;
        logic write;
        logic [31:0] wdata;
    } cpi_cpreq_type;
    // response primitive layout
    typedef struct packed {
        logic comeAgain;
        logic spare;
        logic direction;
        logic [4:0] func;
        logic [2:0] mid;
        logic passCounter;
        logic [3:0] arg;
    } cpi_prim_type;
endpackage

// ---- hw/cpi_msb_align.sv ----
// byte justifier between software data and the operand register
`timescale 1ns/1ps
module cpi_msb_align
    import cpi_pkg::*;
(
    input wire logic [31:0] dataIn,
    input wire logic [2:0] byteCount,
    input wire logic toMsb,
    output logic [31:0] dataOut
);
    logic [5:0] shiftBits; // empty bytes times eight

    // a full long word passes unshifted; a tail moves up or down
    always_comb
    begin
        shiftBits = {3'(3'h4 - byteCount), 3'h0};
        if (toMsb)
        begin
            dataOut = dataIn << shiftBits;
        end
        else
        begin
            dataOut = dataIn >> shiftBits;
        end
    end
endmodule

// ---- hw/cpi_coproc_port.sv ----
// main-processor side engine of the coprocessor interface, AHB-Lite controlled
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "cpi_cfg.svh"
module cpi_coproc_port
    import cpi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output cpi_cpreq_type cpReq,
    output logic cpValid,
    input wire logic cpAck,
    input wire logic [31:0] cpRdata
);
    // bus slave registers
    logic wrPend_reg; // write data phase pending
    logic [7:0] wrAddr_reg;
    logic rdPend_reg; // read wait state pending
    logic [7:0] rdAddr_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic hresp_reg;
    // software-written setup
    cpi_cat_type cat_reg;
    logic [15:0] opWord_reg;
    logic [15:0] cmdWord_reg;
    logic [15:0] cond_reg;
    // sequencer state and data
    cpi_state_type state_reg;
    cpi_state_type ret_reg; // where a coprocessor access returns
    cpi_cpreq_type cpReq_reg;
    logic cpValid_reg;
    logic [31:0] rd_reg; // last coprocessor read data
    cpi_prim_type resp_reg;
    logic [31:0] pcAddr_reg; // operation word address, then next pc
    logic [31:0] scanPtr_reg;
    logic [31:0] opData_reg;
    logic [31:0] opAddr_reg;
    logic [15:0] regSel_reg;
    logic [3:0] remain_reg; // operand bytes still to move
    logic pcPassed_reg;
    logic done_reg;
    logic proto_reg;
    logic opWant_reg;
    logic opReady_reg;
    logic tf_reg;
    // strobes
    logic addrPhase;
    logic wrHit;
    logic swStart;
    logic swOpWrite;
    logic swOpRead;
    logic clrDone;
    logic clrProto;
    logic [2:0] tailCount;
    logic [31:0] wrAligned;
    logic [31:0] rdAligned;
    logic knownFunc;
    logic [31:0] readValue;

    assign hreadyout = hreadyout_reg;
    assign hrdata = hrdata_reg;
    assign hresp = hresp_reg;
    assign cpReq = cpReq_reg;
    assign cpValid = cpValid_reg;

    // decode software strobes from the write data phase; swOpRead from the read wait state
    always_comb
    begin
        addrPhase = hsel && htrans[1] && hready;
        wrHit = wrPend_reg;
        swStart = wrHit && (wrAddr_reg == `CPI_AHB_CTRL) && hwdata[`CPI_CTRL_START]
            && (state_reg == ST_IDLE);
        swOpWrite = wrHit && (wrAddr_reg == `CPI_AHB_OPDATA) && opWant_reg;
        swOpRead = rdPend_reg && (rdAddr_reg == `CPI_AHB_OPDATA) && opReady_reg;
        clrDone = wrHit && (wrAddr_reg == `CPI_AHB_STATUS) && hwdata[`CPI_ST_DONE];
        clrProto = wrHit && (wrAddr_reg == `CPI_AHB_STATUS) && hwdata[`CPI_ST_PROTO];
        // long words first, a shorter tail last
        tailCount = (remain_reg >= `CPI_LONG_BYTES) ? 3'h4 : remain_reg[2:0];
    end

    // tail bytes go up to the top byte on writes
    cpi_msb_align wrAlign (
        .dataIn(opData_reg),
        .byteCount(tailCount),
        .toMsb(1'b1),
        .dataOut(wrAligned)
    );

    // and come back down to the low byte on reads
    cpi_msb_align rdAlign (
        .dataIn(rd_reg),
        .byteCount(tailCount),
        .toMsb(1'b0),
        .dataOut(rdAligned)
    );

    // primitives this engine understands
    always_comb
    begin
        case (resp_reg.func)
            `CPI_FN_NULL, `CPI_FN_OPWORD, `CPI_FN_REGSEL, `CPI_FN_IADDR,
            `CPI_FN_OPADDR, `CPI_FN_EXTSKIP: knownFunc = 1'b1;
            `CPI_FN_OPERAND: knownFunc = (resp_reg.arg != 4'h0); // zero length is illegal
            default: knownFunc = 1'b0;
        endcase
    end

    // register read mux; unmapped offsets read zero
    always_comb
    begin
        case (rdAddr_reg)
            `CPI_AHB_CTRL: readValue = {28'h0000000, cat_reg, 1'b0};
            `CPI_AHB_OPWORD: readValue = {16'h0000, opWord_reg};
            `CPI_AHB_CMD: readValue = {16'h0000, cmdWord_reg};
            `CPI_AHB_COND: readValue = {16'h0000, cond_reg};
            `CPI_AHB_PCADDR: readValue = pcAddr_reg;
            `CPI_AHB_OPDATA: readValue = opData_reg;
            `CPI_AHB_OPADDR: readValue = opAddr_reg;
            `CPI_AHB_STATUS: readValue = {25'h0000000, tf_reg, resp_reg.direction,
                opReady_reg, opWant_reg, proto_reg, done_reg, state_reg != ST_IDLE};
            `CPI_AHB_SCAN: readValue = scanPtr_reg;
            `CPI_AHB_REGSEL: readValue = {16'h0000, regSel_reg};
            `CPI_AHB_RESP: readValue = {16'h0000, resp_reg};
            default: readValue = 32'h00000000;
        endcase
    end

    // AHB-Lite slave: writes zero wait, reads one wait state so that a
    // write just before a read is already visible
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            rdPend_reg <= 1'b0;
            rdAddr_reg <= 8'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h00000000;
            hresp_reg <= 1'b0;
        end
        else
        begin
            hresp_reg <= 1'b0; // always OKAY
            wrPend_reg <= addrPhase && hwrite;
            rdPend_reg <= addrPhase && !hwrite;
            if (addrPhase)
            begin
                wrAddr_reg <= haddr[7:0];
                rdAddr_reg <= haddr[7:0];
            end
            if (addrPhase && !hwrite)
            begin
                hreadyout_reg <= 1'b0; // insert the read wait state
            end
            else if (rdPend_reg)
            begin
                hreadyout_reg <= 1'b1;
                hrdata_reg <= readValue;
            end
        end
    end

    // software setup registers
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cat_reg <= CAT_GENERAL;
            opWord_reg <= 16'h0000;
            cmdWord_reg <= 16'h0000;
            cond_reg <= 16'h0000;
        end
        else if (wrHit)
        begin
            case (wrAddr_reg)
                `CPI_AHB_CTRL: cat_reg <= cpi_cat_type'(hwdata[3:1]);
                `CPI_AHB_OPWORD: opWord_reg <= hwdata[15:0];
                `CPI_AHB_CMD: cmdWord_reg <= hwdata[15:0];
                `CPI_AHB_COND: cond_reg <= hwdata[15:0];
                default: ; // other offsets belong to the sequencer block
            endcase
        end
    end

    // dialogue sequencer with the coprocessor; later assignments win, so a
    // hardware set in the same cycle as a software clear keeps the flag
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            ret_reg <= ST_IDLE;
            cpReq_reg <= '0;
            cpValid_reg <= 1'b0;
            rd_reg <= 32'h00000000;
            resp_reg <= '0;
            pcAddr_reg <= 32'h00000000;
            scanPtr_reg <= 32'h00000000;
            opData_reg <= 32'h00000000;
            opAddr_reg <= 32'h00000000;
            regSel_reg <= 16'h0000;
            remain_reg <= 4'h0;
            pcPassed_reg <= 1'b0;
            done_reg <= 1'b0;
            proto_reg <= 1'b0;
            opWant_reg <= 1'b0;
            opReady_reg <= 1'b0;
            tf_reg <= 1'b0;
        end
        else
        begin
            if (clrDone)
            begin
                done_reg <= 1'b0;
            end
            if (clrProto)
            begin
                proto_reg <= 1'b0;
            end
            // software may preload pc and operand address when idle
            if (wrHit && state_reg == ST_IDLE)
            begin
                if (wrAddr_reg == `CPI_AHB_PCADDR)
                begin
                    pcAddr_reg <= hwdata;
                end
                if (wrAddr_reg == `CPI_AHB_OPADDR)
                begin
                    opAddr_reg <= hwdata;
                end
            end
            if (swOpWrite)
            begin
                opData_reg <= hwdata;
            end
            case (state_reg)
                ST_IDLE:
                begin
                    if (swStart)
                    begin
                        state_reg <= ST_INIT;
                    end
                end
                ST_INIT:
                begin
                    // program counter stays on the operation word
                    cpValid_reg <= 1'b1;
                    ret_reg <= ST_READ_RESP;
                    state_reg <= ST_BUS;
                    case (cat_reg)
                        CAT_BRANCH:
                        begin
                            cpReq_reg <= '{`CPI_CIR_CONDITION, 1'b0, 1'b1,
                                {16'h0000, cond_reg}};
                            scanPtr_reg <= pcAddr_reg + `CPI_WORD_STEP;
                        end
                        CAT_SET, CAT_TRAP, CAT_DBRANCH:
                        begin
                            cpReq_reg <= '{`CPI_CIR_CONDITION, 1'b0, 1'b1,
                                {16'h0000, cond_reg}};
                            scanPtr_reg <= pcAddr_reg + (`CPI_WORD_STEP << 1);
                        end
                        default:
                        begin
                            cpReq_reg <= '{`CPI_CIR_COMMAND, 1'b0, 1'b1,
                                {16'h0000, cmdWord_reg}};
                            scanPtr_reg <= pcAddr_reg + (`CPI_WORD_STEP << 1);
                        end
                    endcase
                end
                ST_READ_RESP:
                begin
                    // each primitive arrives in the base register
                    cpReq_reg <= '{`CPI_CIR_RESPONSE, 1'b0, 1'b0, 32'h00000000};
                    cpValid_reg <= 1'b1;
                    pcPassed_reg <= 1'b0;
                    ret_reg <= ST_LATCH;
                    state_reg <= ST_BUS;
                end
                ST_LATCH:
                begin
                    resp_reg <= cpi_prim_type'(rd_reg[15:0]);
                    state_reg <= ST_DECODE;
                end
                ST_DECODE:
                begin
                    if (resp_reg.passCounter && !pcPassed_reg)
                    begin
                        // counter goes out before any service or exception
                        cpReq_reg <= '{`CPI_CIR_IADDR, 1'b1, 1'b1, pcAddr_reg};
                        cpValid_reg <= 1'b1;
                        pcPassed_reg <= 1'b1;
                        ret_reg <= ST_DECODE;
                        state_reg <= ST_BUS;
                    end
                    else if (!knownFunc)
                    begin
                        proto_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                    else
                    begin
                        case (resp_reg.func)
                            `CPI_FN_OPWORD:
                            begin
                                cpReq_reg <= '{`CPI_CIR_OPWORD, 1'b0, 1'b1,
                                    {16'h0000, opWord_reg}};
                                cpValid_reg <= 1'b1;
                                ret_reg <= ST_FINISH;
                                state_reg <= ST_BUS;
                            end
                            `CPI_FN_OPERAND:
                            begin
                                remain_reg <= resp_reg.arg;
                                state_reg <= ST_OPERAND;
                            end
                            `CPI_FN_REGSEL:
                            begin
                                cpReq_reg <= '{`CPI_CIR_REGSEL, 1'b0, 1'b0,
                                    32'h00000000};
                                cpValid_reg <= 1'b1;
                                ret_reg <= ST_CAPTURE;
                                state_reg <= ST_BUS;
                            end
                            `CPI_FN_IADDR:
                            begin
                                // scan pointer moves in either direction
                                cpReq_reg <= '{`CPI_CIR_IADDR, 1'b1, !resp_reg.direction,
                                    scanPtr_reg};
                                cpValid_reg <= 1'b1;
                                ret_reg <= resp_reg.direction ? ST_CAPTURE : ST_FINISH;
                                state_reg <= ST_BUS;
                            end
                            `CPI_FN_OPADDR:
                            begin
                                cpReq_reg <= '{`CPI_CIR_OPADDR, 1'b1, !resp_reg.direction,
                                    opAddr_reg};
                                cpValid_reg <= 1'b1;
                                ret_reg <= resp_reg.direction ? ST_CAPTURE : ST_FINISH;
                                state_reg <= ST_BUS;
                            end
                            `CPI_FN_EXTSKIP:
                            begin
                                // one word step per extension word referenced
                                scanPtr_reg <= scanPtr_reg
                                    + ({28'h0000000, resp_reg.arg} << 1);
                                state_reg <= ST_FINISH;
                            end
                            default:
                            begin
                                tf_reg <= resp_reg.arg[0]; // null primitive condition
                                state_reg <= ST_FINISH;
                            end
                        endcase
                    end
                end
                ST_CAPTURE:
                begin
                    // route read data by the primitive that asked for it
                    case (resp_reg.func)
                        `CPI_FN_REGSEL: regSel_reg <= rd_reg[15:0];
                        `CPI_FN_IADDR: scanPtr_reg <= rd_reg;
                        default: opAddr_reg <= rd_reg;
                    endcase
                    state_reg <= ST_FINISH;
                end
                ST_OPERAND:
                begin
                    if (remain_reg == 4'h0)
                    begin
                        state_reg <= ST_FINISH;
                    end
                    else if (!resp_reg.direction)
                    begin
                        opWant_reg <= 1'b1; // ask software for the next word
                        state_reg <= ST_OPW_WAIT;
                    end
                    else
                    begin
                        cpReq_reg <= '{`CPI_CIR_OPERAND, 1'b1, 1'b0, 32'h00000000};
                        cpValid_reg <= 1'b1;
                        ret_reg <= ST_OPR_WAIT;
                        state_reg <= ST_BUS;
                    end
                end
                ST_OPW_WAIT:
                begin
                    if (swOpWrite)
                    begin
                        // software word is low-justified; wrAligned follows next cycle
                        opWant_reg <= 1'b0;
                        ret_reg <= ST_OPERAND;
                        state_reg <= ST_BUS;
                        cpValid_reg <= 1'b0;
                    end
                    else if (!opWant_reg)
                    begin
                        // data now stored: send it up-justified
                        cpReq_reg <= '{`CPI_CIR_OPERAND, 1'b1, 1'b1, wrAligned};
                        cpValid_reg <= 1'b1;
                        remain_reg <= remain_reg - {1'b0, tailCount};
                        ret_reg <= ST_OPERAND;
                        state_reg <= ST_BUS;
                    end
                end
                ST_OPR_WAIT:
                begin
                    if (!opReady_reg)
                    begin
                        opData_reg <= rdAligned;
                        opReady_reg <= 1'b1;
                    end
                    else if (swOpRead)
                    begin
                        opReady_reg <= 1'b0;
                        remain_reg <= remain_reg - {1'b0, tailCount};
                        state_reg <= ST_OPERAND;
                    end
                end
                ST_FINISH:
                begin
                    if (resp_reg.comeAgain)
                    begin
                        state_reg <= ST_READ_RESP;
                    end
                    else
                    begin
                        pcAddr_reg <= scanPtr_reg;
                        done_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_BUS:
                begin
                    if (cpValid_reg && cpAck)
                    begin
                        cpValid_reg <= 1'b0;
                        rd_reg <= cpRdata;
                        state_reg <= ret_reg;
                    end
                    else if (!cpValid_reg)
                    begin
                        // parked hop used by the operand write path
                        state_reg <= ST_OPW_WAIT;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- dv/cpi_coproc_port_checker.sv ----
// assertions on the coprocessor side of the interface port
`timescale 1ns/1ps
module cpi_coproc_port_checker
    import cpi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input cpi_cpreq_type cpReq,
    input wire logic cpValid,
    input wire logic cpAck
);
    wire [4:0] adr = cpReq.addr; // register offset of the access
    wire [1:0] kind = {cpReq.write, cpReq.wide}; // 2 is a 16-bit write
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_cmd; cpValid && adr == 5'h0A |-> kind == 2'h2; endproperty
    a_cmd: assert property (p_cmd) else $error("command access");
    property p_cnd; cpValid && adr == 5'h0E |-> kind == 2'h2; endproperty
    a_cnd: assert property (p_cnd) else $error("condition access");
    property p_opd; cpValid && adr == 5'h10 |-> kind[0]; endproperty
    a_opd: assert property (p_opd) else $error("operand width");
    property p_iad; cpValid && adr == 5'h18 |-> kind[0]; endproperty
    a_iad: assert property (p_iad) else $error("address access");
    property p_rsp; cpValid && adr == 5'h00 |-> kind == 2'h0; endproperty
    a_rsp: assert property (p_rsp) else $error("response access");
    // a request may not change under the coprocessor before it answers
    property p_hld; cpValid && !cpAck |=> cpValid && $stable(cpReq); endproperty
    a_hld: assert property (p_hld) else $error("request moved");
    property p_rel; cpValid && cpAck |=> !cpValid; endproperty
    a_rel: assert property (p_rel) else $error("request kept");
    property p_ask; cpAck && adr == 5'h0A |-> ##[1:8] cpValid && adr == 5'h00; endproperty
    a_ask: assert property (p_ask) else $error("no response read");
    c_opd: cover property (cpAck && adr == 5'h10 && kind[1]);
    c_cnd: cover property (cpAck && adr == 5'h0E);
    c_iad: cover property (cpAck && adr == 5'h18);
endmodule
bind cpi_coproc_port cpi_coproc_port_checker i_cpi_coproc_port_checker (.ref_clk(ref_clk),
    .rst(rst), .cpReq(cpReq), .cpValid(cpValid), .cpAck(cpAck));

// ---- dv/cpi_coproc_model.sv ----
// behavioural coprocessor answering the interface port
`timescale 1ns/1ps
module cpi_coproc_model
    import cpi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input cpi_cpreq_type cpReq,
    input wire logic cpValid,
    output logic cpAck,
    output logic [31:0] cpRdata
);
    int lag = 0; // wait cycles before each answer
    int cnt = 0;
    logic [15:0] resp[$]; // scripted primitives, filled by the bench
    cpi_cpreq_type log[$]; // every completed access, address kept too
    // answer after lag cycles; idle data is inverted so stale values never match
    always @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            cpAck <= 1'b0;
            cpRdata <= 32'h0;
        end
        else if (cpValid && !cpAck && cnt >= lag)
        begin
            cpAck <= 1'b1;
            cnt <= 0;
            log.push_back(cpReq); // offset decode
            // response at offset zero, 16 bits
            cpRdata <= (cpReq.addr == 5'h00) ? {16'h0, resp.pop_front()} : 32'hA1B2C3D4;
        end
        else
        begin
            cpAck <= 1'b0;
            cnt <= cnt + int'(cpValid && !cpAck);
            cpRdata <= ~cpRdata;
        end
endmodule

// ---- dv/cpi_coproc_port_tb.sv ----
// self-checking bench for the coprocessor interface port
`timescale 1ns/1ps
`include "cpi_cfg.svh"
module cpi_coproc_port_tb
    import cpi_pkg::*;
;
    logic ref_clk = 0, rst = 1, hwrite = 0, hreadyout, cpValid, cpAck, hresp;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, cpRdata, q;
    cpi_cpreq_type cpReq;
    int miscompares = 0, compares = 0;
    always #10 ref_clk = ~ref_clk;
    cpi_coproc_port i_cpi_coproc_port (.ref_clk(ref_clk), .rst(rst), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .cpReq(cpReq), .cpValid(cpValid), .cpAck(cpAck), .cpRdata(cpRdata));
    cpi_coproc_model i_cpi_coproc_model (.ref_clk(ref_clk), .rst(rst), .cpReq(cpReq),
        .cpValid(cpValid), .cpAck(cpAck), .cpRdata(cpRdata));
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            miscompares++;
            $display("ERROR %0t saw %h expected %h", $time, s, e);
        end
    endtask
    // one single AHB transfer; waits end by count, never open-ended
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (!hreadyout && ++n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (!hreadyout && ++n < 50);
        q = hrdata;
        check(32'(hresp), 32'h0);
        if (n >= 50)
        begin
            check(32'h0, 32'h1);
            print_verdict();
        end
    endtask
    task automatic poll(input int b);
        int n = 0;
        do bus(0, `CPI_AHB_STATUS, 0); while (q[b] !== 1'b1 && ++n < 100);
        check(32'(q[b]), 32'h1);
        if (n >= 100) print_verdict();
    endtask
    task automatic lg(input int k, input logic [4:0] a, input logic [31:0] d);
        check(32'(i_cpi_coproc_model.log[k].addr), 32'(a));
        if (i_cpi_coproc_model.log[k].write) check(i_cpi_coproc_model.log[k].wdata, d);
    endtask
    // clears flags, sets pc 0x1000, writes 0x1234 to register r, then starts category c
    task automatic go(input logic [2:0] c, input logic [7:0] r, input logic [15:0] p0, p1);
        i_cpi_coproc_model.log.delete();
        i_cpi_coproc_model.resp = '{p0, p1};
        i_cpi_coproc_model.lag = int'(c) * 3;
        bus(1, `CPI_AHB_STATUS, 32'h6);
        bus(1, `CPI_AHB_PCADDR, 32'h1000);
        bus(1, r, 32'h1234);
        bus(1, `CPI_AHB_CTRL, {28'h0, c, 1'b1});
    endtask
    task automatic t_gen;
        bus(1, `CPI_AHB_OPWORD, 32'hF200);
        go(3'h0, `CPI_AHB_CMD, 16'h8210, 16'h0300);
        poll(`CPI_ST_DONE);
        lg(0, 5'h0A, 32'h1234);
        lg(4, 5'h08, 32'hF200);
        lg(2, 5'h18, 32'h1000);
        lg(3, 5'h00, 32'h0);
        bus(0, `CPI_AHB_PCADDR, 0);
        check(q, 32'h1004);
    endtask
    task automatic t_br;
        go(3'h1, `CPI_AHB_COND, 16'hA700, 16'h0201);
        poll(`CPI_ST_DONE);
        lg(0, 5'h0E, 32'h1234);
        lg(2, 5'h1C, 32'h0);
        bus(0, `CPI_AHB_OPADDR, 0);
        check(q, 32'hA1B2C3D4);
        bus(0, `CPI_AHB_PCADDR, 0);
        check(q, 32'h1002);
    endtask
    // six bytes out as a long word and a tail, then three bytes back
    task automatic t_opd;
        go(3'h0, `CPI_AHB_CMD, 16'h8406, 16'h2403);
        poll(3);
        bus(1, `CPI_AHB_OPDATA, 32'h11223344);
        poll(3);
        bus(1, `CPI_AHB_OPDATA, 32'h5566);
        poll(4);
        bus(0, `CPI_AHB_OPDATA, 0);
        check(q, 32'h00A1B2C3);
        lg(2, 5'h10, 32'h11223344);
        lg(3, 5'h10, 32'h55660000);
        lg(5, 5'h10, 32'h0);
    endtask
    task automatic t_bad;
        go(3'h0, `CPI_AHB_CMD, 16'h1F10, 16'h0);
        poll(`CPI_ST_PROTO);
        lg(2, 5'h18, 32'h1000);
        bus(0, 8'hFC, 0);
        check(q, 32'h0);
    endtask
    task automatic print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #1000000;
        miscompares++;
        print_verdict();
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_gen();
        t_br();
        t_opd();
        t_bad();
        print_verdict();
    end
endmodule
